// ===== rtl/sadc_ctrl.sv
// sadc_ctrl: control of a two-channel 12-bit successive-approximation
// converter: registers, channel sequencing, conversion timing.
// assumes the analog front end presents its finished code on
// conv_result while conv_channel_q stays put, from another domain.
//
// Behaviour
// - channel-1 low register: bits 3..0 at 7..4
// - channel-1 high register: result bits 11..4
// - results update on completion, reset to zero
// - loop select bit 0: single or continuous
// - run bit 0 starts and stops conversion
// - single mode clears run after last channel
// - mode bits 0/1 enable channel 0/1
// - convert lowest selected channel first, upward
// - no channels: powered, idle, run stays set
// - input zero to result 0, one to 1
// - disabled channel results keep their contents
// - termination pulse after last channel stored
// - continuous mode restarts from lowest channel
// - channel selection latched until termination
// - each conversion takes 46 microseconds
// - channel-0 results use the channel-1 layout
`default_nettype none

module sadc_ctrl #(
    parameter int CONV_CYCLES = sadc_pkg::CONV_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    input  wire logic [sadc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sadc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [sadc_pkg::DATA_W-1:0] reg_rdata_q,
    input  wire logic [sadc_pkg::RES_W-1:0]  conv_result,
    output var  logic                        conv_power_q,
    output var  logic                        conv_channel_q,
    output var  logic                        conv_sample_q,
    output var  logic                        conversion_done_irq_q
);
    import sadc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    function automatic logic lowest(input logic [NUM_CH-1:0] en);
        lowest = !en[EN_CH0_BIT];
    endfunction

    function automatic logic highest(input logic [NUM_CH-1:0] en);
        highest = en[EN_CH1_BIT];
    endfunction

    function automatic logic [DATA_W-1:0] low_byte(
        input logic [RES_W-1:0] r);
        low_byte = {r[LOW_MSB:0], LOW_PAD};
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0]          loop_q;
    logic [DATA_W-1:0]          run_q;
    logic [DATA_W-1:0]          chsel_q;
    logic [NUM_CH-1:0]          latch_q;
    logic [CNT_W-1:0]           cnt_q;
    logic [RES_W-1:0]           res_meta_q;
    logic [RES_W-1:0]           res_sync_q;
    sadc_state_e                st_q;
    sadc_state_e                st_d;
    sadc_res_wr_s               res_wr;
    logic [NUM_CH-1:0][RES_W-1:0] words;
    logic [NUM_CH-1:0]          ch_en;
    logic                       sw_run_wr;
    logic                       run_start;
    logic                       sw_stop;
    logic                       last_ch;
    logic                       wrap;
    logic                       enter_conv;
    logic                       loop_mode;

    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    assign ch_en     = chsel_q[NUM_CH-1:0];
    assign loop_mode = loop_q[LOOP_SELECT_BIT];
    assign sw_run_wr = reg_wr && hit(reg_addr, ADDR_RUN);
    assign run_start = sw_run_wr && reg_wdata[RUN_BIT]
                       && (st_q == SADC_IDLE);
    assign sw_stop   = sw_run_wr && !reg_wdata[RUN_BIT];
    assign last_ch   = (conv_channel_q == highest(latch_q));
    assign wrap      = (st_q == SADC_STORE) && last_ch;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // loop select is taken whenever written; software keeps it
    // steady during a run, so no interlock here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            loop_q <= RST_LOOP;
        end else if (reg_wr && hit(reg_addr, ADDR_LOOP)) begin
            loop_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chsel_q <= RST_CHSEL;
        end else if (reg_wr && hit(reg_addr, ADDR_CHSEL)) begin
            chsel_q <= reg_wdata;
        end
    end

    // a software write in the same cycle beats the automatic clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run_q <= RST_RUN;
        end else if (sw_run_wr) begin
            run_q <= reg_wdata;
        end else if (wrap && !loop_mode) begin
            run_q[RUN_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result input synchroniser
    // ------------------------------------------------------------
    // the code is sampled only long after the channel settles,
    // so a plain two-flop bus crossing is safe here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            res_meta_q <= '0;
            res_sync_q <= '0;
        end else begin
            res_meta_q <= conv_result;
            res_sync_q <= res_meta_q;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SADC_IDLE: begin
                if (run_start) begin
                    st_d = (ch_en == NO_CH) ? SADC_HOLD
                                            : SADC_CONV;
                end
            end
            SADC_CONV: begin
                if (cnt_q == CNT_ZERO) begin
                    st_d = SADC_STORE;
                end
            end
            SADC_STORE: begin
                if (!last_ch) begin
                    st_d = SADC_CONV;
                end else if (!loop_mode) begin
                    st_d = SADC_IDLE;
                end else begin
                    st_d = (ch_en == NO_CH) ? SADC_HOLD
                                            : SADC_CONV;
                end
            end
            SADC_HOLD: begin
                st_d = SADC_HOLD;
            end
        endcase
        if (sw_stop) begin
            st_d = SADC_IDLE;
        end
    end

    assign enter_conv = (st_d == SADC_CONV) && (st_q != SADC_CONV);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= SADC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // selection is frozen from start until the termination pulse
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_q <= NO_CH;
        end else if (run_start || (wrap && loop_mode)) begin
            latch_q <= ch_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_channel_q <= 1'b0;
        end else if (run_start || wrap) begin
            conv_channel_q <= lowest(ch_en);
        end else if (st_q == SADC_STORE) begin
            conv_channel_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= CNT_ZERO;
        end else if (enter_conv) begin
            cnt_q <= CNT_LOAD;
        end else if (st_q == SADC_CONV && cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // front end and event outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_power_q          <= 1'b0;
            conv_sample_q         <= 1'b0;
            conversion_done_irq_q <= 1'b0;
        end else begin
            conv_power_q          <= (st_d != SADC_IDLE);
            conv_sample_q         <= enter_conv;
            conversion_done_irq_q <= wrap;
        end
    end

    // ------------------------------------------------------------
    // result storage
    // ------------------------------------------------------------
    always_comb begin
        res_wr.valid = (st_q == SADC_STORE);
        res_wr.chan  = conv_channel_q;
        res_wr.data  = res_sync_q;
    end

    sadc_result_store #(
        .W (RES_W),
        .N (NUM_CH)
    ) u_store (
        .clk     (sys_clk),
        .srst    (srst),
        .wr      (res_wr),
        .words_q (words)
    );

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // result addresses have no write decode at all
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q <= RD_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CH0_LOW:  reg_rdata_q <= low_byte(words[0]);
                ADDR_CH0_HIGH: reg_rdata_q <=
                    words[0][HIGH_MSB:HIGH_LSB];
                ADDR_CH1_LOW:  reg_rdata_q <= low_byte(words[1]);
                ADDR_CH1_HIGH: reg_rdata_q <=
                    words[1][HIGH_MSB:HIGH_LSB];
                ADDR_LOOP:     reg_rdata_q <= loop_q;
                ADDR_RUN:      reg_rdata_q <= run_q;
                ADDR_CHSEL:    reg_rdata_q <= chsel_q;
                default:       reg_rdata_q <= RD_ZERO;
            endcase
        end else begin
            reg_rdata_q <= RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    low_layout_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_rd && reg_addr == ADDR_CH1_LOW |=>
            reg_rdata_q == {$past(words[1][LOW_MSB:0]), LOW_PAD})
        else $error("channel 1 low byte layout wrong");

    high_layout_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_rd && reg_addr == ADDR_CH1_HIGH |=>
            reg_rdata_q == $past(words[1][HIGH_MSB:HIGH_LSB]))
        else $error("channel 1 high byte layout wrong");

    store_update_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        st_q == SADC_STORE |=>
            words[$past(conv_channel_q)] == $past(res_sync_q))
        else $error("result not stored on completion");

    single_stop_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        wrap && !loop_mode && !sw_run_wr |=>
            !run_q[RUN_BIT] && st_q == SADC_IDLE)
        else $error("single mode did not clear run");

    order_up_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        st_q == SADC_STORE && !last_ch && !sw_stop |=>
            conv_channel_q && st_q == SADC_CONV)
        else $error("channel order not upward");

    empty_hold_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        st_q == SADC_HOLD |->
            (run_q[RUN_BIT] && conv_power_q && !res_wr.valid)
            ##1 !conversion_done_irq_q)
        else $error("empty selection did something");

    skip_disabled_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        res_wr.valid |-> latch_q[res_wr.chan])
        else $error("disabled channel result written");

    irq_cause_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        conversion_done_irq_q |->
            $past(st_q) == SADC_STORE && $past(last_ch))
        else $error("termination pulse without last store");

    loop_restart_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        wrap && loop_mode && !sw_run_wr && ch_en != NO_CH |=>
            st_q == SADC_CONV && run_q[RUN_BIT]
            && conv_channel_q == lowest($past(ch_en)))
        else $error("continuous mode did not restart");

    latch_hold_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        st_q != SADC_IDLE && !wrap |=> $stable(latch_q))
        else $error("selection changed mid run");

    conv_time_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(st_q == SADC_CONV) |->
            cnt_q == CNT_LOAD && conv_sample_q)
        else $error("conversion time load wrong");

    ro_write_a: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_wr && !res_wr.valid |=> $stable(words))
        else $error("write altered results");

endmodule

`default_nettype wire

// ===== pkg/sadc_pkg.sv
// sadc_pkg: constants, types and register map of the two-channel
// successive-approximation converter control block.
// assumes a 50 MHz system clock and an 8-bit register port.
`default_nettype none

package sadc_pkg;

    // ------------------------------------------------------------
    // register port and map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_CH0_LOW  = 16'hf2d0;
    localparam logic [ADDR_W-1:0] ADDR_CH0_HIGH = 16'hf2d1;
    localparam logic [ADDR_W-1:0] ADDR_CH1_LOW  = 16'hf2d2;
    localparam logic [ADDR_W-1:0] ADDR_CH1_HIGH = 16'hf2d3;
    localparam logic [ADDR_W-1:0] ADDR_LOOP     = 16'hf2f0;
    localparam logic [ADDR_W-1:0] ADDR_RUN      = 16'hf2f1;
    localparam logic [ADDR_W-1:0] ADDR_CHSEL    = 16'hf2f2;

    localparam logic [DATA_W-1:0] RST_LOOP  = 8'h02;
    localparam logic [DATA_W-1:0] RST_RUN   = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHSEL = 8'h00;
    localparam logic [DATA_W-1:0] RD_ZERO   = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LOOP_SELECT_BIT = 0;
    localparam int RUN_BIT         = 0;
    localparam int EN_CH0_BIT      = 0;
    localparam int EN_CH1_BIT      = 1;

    // ------------------------------------------------------------
    // result layout
    // ------------------------------------------------------------
    localparam int RES_W      = 12;
    localparam int NUM_CH     = 2;
    localparam int LOW_NIB_W  = 4;
    localparam int HIGH_MSB   = 11;
    localparam int HIGH_LSB   = 4;
    localparam int LOW_MSB    = 3;
    localparam logic [LOW_NIB_W-1:0] LOW_PAD = 4'h0;
    localparam logic [NUM_CH-1:0]    NO_CH   = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS  = 46000;
    localparam int CONV_CYCLES   =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SADC_IDLE  = 2'h0,
        SADC_CONV  = 2'h1,
        SADC_STORE = 2'h3,
        SADC_HOLD  = 2'h2
    } sadc_state_e;

    typedef struct packed {
        logic             valid;
        logic             chan;
        logic [RES_W-1:0] data;
    } sadc_res_wr_s;

endpackage

`default_nettype wire

// ===== rtl/sadc_result_store.sv
// sadc_result_store: per-channel conversion result words.
// assumes one write per cycle; words come straight out of flops.
`default_nettype none

module sadc_result_store #(
    parameter int W = 12,
    parameter int N = 2
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire sadc_pkg::sadc_res_wr_s wr,
    output var  logic [N-1:0][W-1:0]   words_q
);
    import sadc_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            words_q <= '0;
        end else if (wr.valid) begin
            words_q[wr.chan] <= wr.data[W-1:0];
        end
    end

endmodule

`default_nettype wire

// ===== testbench/sadc_afe_model.sv
// sadc_afe_model: behavioural analog front end with two inputs.
// assumes the bench sets the code of each input; slow settles late.
`default_nettype none

module sadc_afe_model (
    input  wire logic                       sys_clk,
    input  wire logic                       conv_power_q,
    input  wire logic                       conv_channel_q,
    input  wire logic                       conv_sample_q,
    input  wire logic [sadc_pkg::RES_W-1:0] code0,
    input  wire logic [sadc_pkg::RES_W-1:0] code1,
    input  wire logic                       slow,
    output var  logic [sadc_pkg::RES_W-1:0] conv_result
);
    timeunit 1ns;
    timeprecision 1ps;
    import sadc_pkg::*;

    localparam int SETTLE = 5;
    int settle_cnt = 0;

    initial conv_result = '0;

    // ------------------------------------------------------------
    // output code
    // ------------------------------------------------------------
    // unpowered or unsettled: keep moving so stale codes never match
    always @(posedge sys_clk) begin
        if (conv_power_q !== 1'b1) begin
            conv_result <= ~conv_result;
            settle_cnt  <= 0;
        end else if (conv_sample_q === 1'b1 && slow) begin
            conv_result <= ~conv_result;
            settle_cnt  <= SETTLE;
        end else if (settle_cnt != 0) begin
            conv_result <= ~conv_result;
            settle_cnt  <= settle_cnt - 1;
        end else begin
            conv_result <= conv_channel_q ? code1 : code0;
        end
    end
endmodule

`default_nettype wire

// ===== testbench/tb_two_channel_sar_adc_control.sv
// tb_two_channel_sar_adc_control: register-level bench for sadc_ctrl.
// assumes sadc_afe_model on the analog side and a short conversion.
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_two_channel_sar_adc_control;
    timeunit 1ns;
    timeprecision 1ps;
    import sadc_pkg::*;

    localparam int CONV = 16;

    logic              sys_clk   = 1'b0;
    logic              srst      = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata_q;
    logic [RES_W-1:0]  conv_result;
    logic              conv_power_q;
    logic              conv_channel_q;
    logic              conv_sample_q;
    logic              conversion_done_irq_q;
    logic [RES_W-1:0]  code0     = '0;
    logic [RES_W-1:0]  code1     = '0;
    logic              slow      = 1'b0;
    int                num_errors = 0;
    int                checked    = 0;
    int                irq_count  = 0;
    int                k;
    logic              chan_seen[$];

    sadc_ctrl #(.CONV_CYCLES(CONV)) uut (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .conv_result(conv_result),
        .conv_power_q(conv_power_q), .conv_channel_q(conv_channel_q),
        .conv_sample_q(conv_sample_q),
        .conversion_done_irq_q(conversion_done_irq_q));

    sadc_afe_model afe (
        .sys_clk(sys_clk), .conv_power_q(conv_power_q),
        .conv_channel_q(conv_channel_q), .conv_sample_q(conv_sample_q),
        .code0(code0), .code1(code1), .slow(slow),
        .conv_result(conv_result));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // monitors and tasks
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (conv_sample_q === 1'b1)
            chan_seen.push_back(conv_channel_q);
        if (conversion_done_irq_q === 1'b1)
            irq_count++;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e, input string what);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(what, e, reg_rdata_q)
        @(posedge sys_clk);
    endtask

    // n0 edges since the run write was launched; exp < 0 skips the count
    task automatic wait_irq(input int n0, input int exp);
        int n;
        n = n0;
        #1;
        while (conversion_done_irq_q !== 1'b1 && n < 4 * CONV + 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (conversion_done_irq_q !== 1'b1) begin
            num_errors++;
            $display("Error irq wait expected 1 seen 0");
            stop_test();
        end
        if (exp >= 0)
            `CHK("irq delay", exp, n)
        @(posedge sys_clk);
        #1;
        `CHK("irq width", 1'b0, conversion_done_irq_q)
        // back on the edge so the next strobe is launched there
        @(posedge sys_clk);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);

        rd(ADDR_CH0_LOW, 8'h00, "ch0 low");
        rd(ADDR_CH0_HIGH, 8'h00, "ch0 high");
        rd(ADDR_CH1_LOW, 8'h00, "ch1 low");
        rd(ADDR_CH1_HIGH, 8'h00, "ch1 high");
        rd(ADDR_LOOP, 8'h02, "loop");
        rd(ADDR_RUN, 8'h00, "run");
        rd(ADDR_CHSEL, 8'h00, "chsel");
        rd(16'hf2f3, 8'h00, "unmapped");
        wr(ADDR_LOOP, 8'ha4);
        rd(ADDR_LOOP, 8'ha4, "loop rw");
        wr(ADDR_LOOP, 8'h00);
        done("reset");

        code1 <= 12'habc;
        wr(ADDR_CHSEL, 8'h02);
        wr(ADDR_RUN, 8'h01);
        wait_irq(2, CONV + 2);
        rd(ADDR_RUN, 8'h00, "run cleared");
        `CHK("power off", 1'b0, conv_power_q)
        rd(ADDR_CH1_LOW, 8'hc0, "ch1 low");
        rd(ADDR_CH1_HIGH, 8'hab, "ch1 high");
        rd(ADDR_CH0_HIGH, 8'h00, "ch0 kept");
        `CHK("samples", 1, chan_seen.size())
        `CHK("sample chan", 1'b1, chan_seen[0])
        done("single ch1");

        slow  <= 1'b1;
        code0 <= 12'h123;
        code1 <= 12'h456;
        chan_seen.delete();
        wr(ADDR_CHSEL, 8'h03);
        wr(ADDR_RUN, 8'h01);
        wr(ADDR_CHSEL, 8'h01);
        wait_irq(4, 2 * CONV + 3);
        rd(ADDR_CH0_LOW, 8'h30, "ch0 low");
        rd(ADDR_CH0_HIGH, 8'h12, "ch0 high");
        rd(ADDR_CH1_LOW, 8'h60, "ch1 low");
        rd(ADDR_CH1_HIGH, 8'h45, "ch1 high");
        rd(ADDR_CHSEL, 8'h01, "chsel kept");
        `CHK("samples", 2, chan_seen.size())
        `CHK("first chan", 1'b0, chan_seen[0])
        `CHK("second chan", 1'b1, chan_seen[1])
        wr(ADDR_CH1_HIGH, 8'hff);
        wr(ADDR_CH1_LOW, 8'h0f);
        rd(ADDR_CH1_HIGH, 8'h45, "ro high");
        rd(ADDR_CH1_LOW, 8'h60, "ro low");
        done("both channels");

        slow  <= 1'b0;
        code1 <= 12'h7e5;
        wr(ADDR_LOOP, 8'h01);
        wr(ADDR_CHSEL, 8'h02);
        wr(ADDR_RUN, 8'h01);
        wait_irq(2, CONV + 2);
        rd(ADDR_RUN, 8'h01, "run kept");
        rd(ADDR_CH1_HIGH, 8'h7e, "loop 1st");
        code1 <= 12'h2f1;
        wait_irq(0, -1);
        rd(ADDR_CH1_HIGH, 8'h2f, "loop 2nd");
        rd(ADDR_CH1_LOW, 8'h10, "loop low");
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_LOOP, 8'h00);
        rd(ADDR_RUN, 8'h00, "loop stop");
        done("continuous");

        // empty selection is a deliberate misuse here
        k = irq_count;
        wr(ADDR_CHSEL, 8'h00);
        wr(ADDR_RUN, 8'h01);
        repeat (3 * CONV) @(posedge sys_clk);
        #1;
        `CHK("empty irq", k, irq_count)
        `CHK("empty power", 1'b1, conv_power_q)
        @(posedge sys_clk);
        rd(ADDR_RUN, 8'h01, "empty run");
        rd(ADDR_CH1_HIGH, 8'h2f, "empty kept");
        wr(ADDR_RUN, 8'h00);
        done("empty selection");

        code0 <= 12'hfff;
        wr(ADDR_CHSEL, 8'h01);
        wr(ADDR_RUN, 8'h01);
        repeat (3) @(posedge sys_clk);
        wr(ADDR_RUN, 8'h00);
        repeat (2 * CONV) @(posedge sys_clk);
        #1;
        `CHK("stop irq", k, irq_count)
        `CHK("stop power", 1'b0, conv_power_q)
        @(posedge sys_clk);
        rd(ADDR_CH0_HIGH, 8'h12, "stop kept");
        done("stop");

        stop_test();
    end
endmodule

`default_nettype wire
